// [core/hfac_consts.vh]
/*
  constants for the fast crystal autostart clock control block: register offsets,
  field positions, reset values, energy mode codes and source select codes.
  assumes it is included by bare name from the core design files.
*/
`ifndef HFAC_CONSTS_VH
`define HFAC_CONSTS_VH

// register byte offsets
`define HFAC_OFS_CTRL 8'h00
`define HFAC_OFS_XCTRL 8'h04
`define HFAC_OFS_OSCCMD 8'h08
`define HFAC_OFS_SELCMD 8'h0C
`define HFAC_OFS_STATUS 8'h10
`define HFAC_OFS_FLAGS 8'h14
`define HFAC_OFS_FLAGCLR 8'h18
`define HFAC_OFS_FLAGEN 8'h1C
`define HFAC_OFS_XCFG 8'h20
`define HFAC_OFS_ROUTE 8'h24
`define HFAC_OFS_EXPDIV 8'h28
`define HFAC_OFS_RETAIN 8'h2C

// control register fields
`define HFAC_CTRL_SEL0_LSB 0
`define HFAC_CTRL_SEL1_LSB 5
`define HFAC_CTRL_WAIT_BIT 16
`define HFAC_CTRL_RESET 32'h0000_0000

// crystal control fields
`define HFAC_XCTRL_AEN_BIT 0
`define HFAC_XCTRL_ASEL_BIT 1

// oscillator command bits (write one)
`define HFAC_CMD_XEN_BIT 0
`define HFAC_CMD_XDIS_BIT 1
`define HFAC_CMD_RCEN_BIT 2
`define HFAC_CMD_RCDIS_BIT 3

// flag bits
`define HFAC_FLG_DISERR 0
`define HFAC_FLG_AUTOSW 1
`define HFAC_FLG_RCOFF 2
`define HFAC_FLG_CFGERR 3
`define HFAC_FLG_W 4

// retain register bits
`define HFAC_RET_SLOW 0
`define HFAC_RET_ULTRA 1
`define HFAC_RET_LFE 2
`define HFAC_RET_CRYO 3
`define HFAC_RET_RFS 4
`define HFAC_RET_ADC 5
`define HFAC_RET_ULF_SRC 6

// energy modes
`define HFAC_EM_ACTIVE 3'h0
`define HFAC_EM_SLEEP 3'h1
`define HFAC_EM_DEEP 3'h2
`define HFAC_EM_STOP 3'h3
`define HFAC_EM_HIBER 3'h4
`define HFAC_EM_SHUT 3'h5

// main source select codes
`define HFAC_SRC_RC 2'h0
`define HFAC_SRC_XTAL 2'h1
`define HFAC_SRC_SLOWX 2'h2
`define HFAC_SRC_SLOWRC 2'h3

// output select codes
`define HFAC_OUT_OFF 4'h0
`define HFAC_OUT_ULF 4'h1
`define HFAC_OUT_LRC 4'h2
`define HFAC_OUT_LXT 4'h3
`define HFAC_OUT_HXT 4'h6
`define HFAC_OUT_EXP 4'h7
`define HFAC_OUT_ULFQ 4'h9
`define HFAC_OUT_LRCQ 4'hA
`define HFAC_OUT_LXTQ 4'hB
`define HFAC_OUT_HRCQ 4'hC
`define HFAC_OUT_AUXQ 4'hD
`define HFAC_OUT_HXTQ 4'hE
`define HFAC_OUT_SRC 4'hF

`endif

// [core/hfac_divider.v]
/*
  export prescaler: divides the main clock stand-in by ratio+1 into a
  roughly half duty level. assumes one clock, synchronous reset.
*/
`timescale 1ns/1ps
module hfac_divider #(
  parameter W = 5
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // control
  input wire [W-1:0] i_ratio,
  input wire i_run,
  // output
  output reg o_level
);
  reg [W-1:0] cnt_reg;

  // exported clock is the main clock divided by ratio+1; even ratios give skewed duty
  always @(posedge i_core_clk) begin
    if (i_rst || !i_run) begin
      cnt_reg <= {W{1'b0}};
      o_level <= 1'b0;
    end else begin
      if (cnt_reg >= i_ratio) begin
        cnt_reg <= {W{1'b0}};
      end else begin
        cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      end
      // one extra bit so the largest ratio does not wrap and kill the clock
      o_level <= ({1'b0, cnt_reg} <
        (({1'b0, i_ratio} + {{W{1'b0}}, 1'b1}) >> 1)) ? 1'b1 : 1'b0;
    end
  end
endmodule

// [core/hfac_qualify.v]
/*
  qualifier for one oscillator: synchronises its ready pin through three stages
  and passes the raw clock level only once ready has been seen steady.
  assumes the ready pin comes from outside the core clock domain.
*/
`timescale 1ns/1ps
module hfac_qualify (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // oscillator side
  input wire i_ready,
  input wire i_clk_level,
  // qualified outputs
  output reg o_ready,
  output wire o_qual
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      s1_reg <= i_ready;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        o_ready <= s2_reg;
      end
    end
  end

  // gating until ready hides start-up glitches and duty skew
  assign o_qual = o_ready & i_clk_level;
endmodule

// [core/hfac_clock_ctrl.v]
/*
  fast crystal autostart clock control: energy-mode oscillator gating,
  autostart enable/select of the fast crystal, error and status flags,
  two clock output pins and the low-power bus wait-state bit.
  assumes a register master on the plain strobe port, oscillator enables
  consumed by analog blocks, and ready pins arriving asynchronously.
*/
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "hfac_consts.vh"

// Contract
// - auto-enable fast crystal in active/sleep when either autostart bit set
// - auto-select fast crystal in active/sleep when autostart-select bit set
// - crystal disable ignored under auto-enable; sets disable error flag
// - other source select ignored under auto-select; sets disable error flag
// - these ignored attempts never set the configuration error flag
// - without autostart, disable/deselect always honoured, no error flag
// - hardware turns crystal off only entering deep-sleep, stop or hibernate/shutoff
// - auto-select switches source at once, not waiting for crystal ready
// - automatic switch to crystal sets the auto-switch flag
// - after auto switch, fast RC turned off if running, flag raised
// - wait bit inserts low-power bus wait states; required above 32 MHz
// - fast oscillators and clocks on in active/sleep, off from deep-sleep
// - aux RC off in deep-sleep/stop unless ADC uses it, off in hibernate/shutoff; code also keeps it on in deep-sleep/stop when the ADC retain bit is set
// - slow oscillators on except stop; hibernate/shutoff only when retained
// - ultra-slow RC always on except shutoff unless retained
// - in stop, low-freq clocks run only with ultra-slow RC source
// - hibernate: E, cryo, RF retainable; shutoff: cryo, RF only
// - two clock pins with own selects, each gated by its pin enable
// - qualified clocks glitch-free; exported clock is main clock over prescaler
// - crystal timing registers written while busy set configuration error flag
module hfac_clock_ctrl #(
  parameter DIVW = 5
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // energy mode and requests
  input wire [2:0] i_energy_mode,
  input wire i_crystal_request,
  input wire i_crystal_sync_busy,
  input wire i_adc_uses_aux,
  // oscillator ready pins and raw clock levels
  input wire i_fast_crystal_osc_ready,
  input wire i_fast_rc_osc_ready,
  input wire i_fast_crystal_osc_clk,
  input wire i_fast_rc_osc_clk,
  input wire i_aux_fast_rc_osc_clk,
  input wire i_slow_rc_osc_clk,
  input wire i_slow_crystal_osc_clk,
  input wire i_ultra_slow_rc_osc_clk,
  // oscillator enables
  output reg o_fast_crystal_osc_en,
  output reg o_fast_rc_osc_en,
  output reg o_aux_fast_rc_osc_en,
  output reg o_slow_rc_osc_en,
  output reg o_slow_crystal_osc_en,
  output reg o_ultra_slow_rc_osc_en,
  // clock gates
  output reg [1:0] o_source_clock_sel,
  output reg o_main_clock_en,
  output reg o_aux_clock_en,
  output reg o_low_freq_a_clock_en,
  output reg o_low_freq_b_clock_en,
  output reg o_low_freq_e_clock_en,
  output reg o_watchdog_clock_en,
  output reg o_cryo_timer_clock_en,
  output reg o_rf_sense_clock_en,
  output reg o_low_power_bus_wait,
  // pins and interrupt
  output reg o_clk_out0,
  output reg o_clk_out1,
  output reg o_irq
);
  reg [31:0] ctrl_reg;
  reg [1:0] auto_reg;
  reg [1:0] pen_reg;
  reg [DIVW-1:0] expdiv_reg;
  reg [6:0] retain_reg;
  reg [`HFAC_FLG_W-1:0] flags_reg;
  reg [`HFAC_FLG_W-1:0] flagen_reg;
  reg xtal_sw_reg;
  reg rc_sw_reg;
  reg [1:0] sel_reg;
  reg [`HFAC_FLG_W-1:0] set_next;
  reg [31:0] rdata_next;

  wire xtal_ready;
  wire rc_ready;
  wire xtal_q;
  wire rc_q;
  wire exp_level;

  wire hf_mode = (i_energy_mode == `HFAC_EM_ACTIVE) || (i_energy_mode == `HFAC_EM_SLEEP);
  wire auto_en = hf_mode && (auto_reg[`HFAC_XCTRL_AEN_BIT] || auto_reg[`HFAC_XCTRL_ASEL_BIT]);
  wire auto_sel = hf_mode && auto_reg[`HFAC_XCTRL_ASEL_BIT];
  wire em_stop = (i_energy_mode == `HFAC_EM_STOP);
  wire em_hib = (i_energy_mode == `HFAC_EM_HIBER);
  wire em_shut = (i_energy_mode == `HFAC_EM_SHUT);
  wire em_low = !hf_mode;
  wire wr_cmd = i_wr && (i_addr == `HFAC_OFS_OSCCMD);
  wire wr_sel = i_wr && (i_addr == `HFAC_OFS_SELCMD);
  wire dis_try = wr_cmd && i_wdata[`HFAC_CMD_XDIS_BIT];
  wire desel_try = wr_sel && (i_wdata[1:0] != `HFAC_SRC_XTAL);
  wire switching = auto_sel && (sel_reg != `HFAC_SRC_XTAL);

  hfac_qualify u_q_xtal (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ready(i_fast_crystal_osc_ready),
    .i_clk_level(i_fast_crystal_osc_clk),
    .o_ready(xtal_ready),
    .o_qual(xtal_q)
  );

  hfac_qualify u_q_rc (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ready(i_fast_rc_osc_ready),
    .i_clk_level(i_fast_rc_osc_clk),
    .o_ready(rc_ready),
    .o_qual(rc_q)
  );

  hfac_divider #(
    .W(DIVW)
  ) u_exp (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ratio(expdiv_reg),
    .i_run(o_main_clock_en),
    .o_level(exp_level)
  );

  // output multiplexer, shared by both pins
  function hfac_pick;
    input [3:0] sel;
    input xq;
    input rq;
    input ex;
    begin
      case (sel)
        `HFAC_OUT_ULF: hfac_pick = i_ultra_slow_rc_osc_clk;
        `HFAC_OUT_LRC: hfac_pick = i_slow_rc_osc_clk;
        `HFAC_OUT_LXT: hfac_pick = i_slow_crystal_osc_clk;
        `HFAC_OUT_HXT: hfac_pick = i_fast_crystal_osc_clk;
        `HFAC_OUT_EXP: hfac_pick = ex;
        `HFAC_OUT_ULFQ: hfac_pick = i_ultra_slow_rc_osc_clk & o_ultra_slow_rc_osc_en;
        `HFAC_OUT_LRCQ: hfac_pick = i_slow_rc_osc_clk & o_slow_rc_osc_en;
        `HFAC_OUT_LXTQ: hfac_pick = i_slow_crystal_osc_clk & o_slow_crystal_osc_en;
        `HFAC_OUT_HRCQ: hfac_pick = rq;
        `HFAC_OUT_AUXQ: hfac_pick = i_aux_fast_rc_osc_clk & o_aux_fast_rc_osc_en;
        `HFAC_OUT_HXTQ: hfac_pick = xq;
        `HFAC_OUT_SRC: hfac_pick = (sel_reg == `HFAC_SRC_XTAL) ? xq : rq;
        default: hfac_pick = 1'b0;
      endcase
    end
  endfunction

  // hardware flag sources for this cycle
  always @* begin
    set_next = {`HFAC_FLG_W{1'b0}};
    set_next[`HFAC_FLG_DISERR] = (dis_try && auto_en) || (desel_try && auto_sel);
    set_next[`HFAC_FLG_AUTOSW] = switching;
    set_next[`HFAC_FLG_RCOFF] = switching && rc_sw_reg;
    // ignored disable/deselect never counts as a configuration error
    set_next[`HFAC_FLG_CFGERR] = i_wr && (i_addr == `HFAC_OFS_XCFG) && i_crystal_sync_busy;
  end

  // software registers, commands and source selection
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_reg <= `HFAC_CTRL_RESET;
      auto_reg <= 2'h0;
      pen_reg <= 2'h0;
      expdiv_reg <= {DIVW{1'b0}};
      retain_reg <= 7'h00;
      flagen_reg <= {`HFAC_FLG_W{1'b0}};
      flags_reg <= {`HFAC_FLG_W{1'b0}};
      xtal_sw_reg <= 1'b0;
      rc_sw_reg <= 1'b1;
      sel_reg <= `HFAC_SRC_RC;
    end else begin
      if (i_wr) begin
        case (i_addr)
          `HFAC_OFS_CTRL: ctrl_reg <= i_wdata & 32'h0001_01EF;
          `HFAC_OFS_XCTRL: auto_reg <= i_wdata[1:0];
          `HFAC_OFS_FLAGEN: flagen_reg <= i_wdata[`HFAC_FLG_W-1:0];
          `HFAC_OFS_ROUTE: pen_reg <= i_wdata[1:0];
          `HFAC_OFS_EXPDIV: expdiv_reg <= i_wdata[DIVW-1:0];
          `HFAC_OFS_RETAIN: retain_reg <= i_wdata[6:0];
          default: ;
        endcase
      end
      // hardware set beats a simultaneous software clear
      flags_reg <= (flags_reg & ~((i_wr && (i_addr == `HFAC_OFS_FLAGCLR)) ?
        i_wdata[`HFAC_FLG_W-1:0] : {`HFAC_FLG_W{1'b0}})) | set_next;
      if (em_low) begin
        xtal_sw_reg <= 1'b0;
        rc_sw_reg <= 1'b1;
        sel_reg <= `HFAC_SRC_RC;
      end else begin
        if (wr_cmd && i_wdata[`HFAC_CMD_XEN_BIT]) begin
          xtal_sw_reg <= 1'b1;
        end else if (dis_try && !auto_en) begin
          xtal_sw_reg <= 1'b0;
        end
        if (switching) begin
          sel_reg <= `HFAC_SRC_XTAL;
          rc_sw_reg <= 1'b0;
        end else begin
          if (wr_sel && !(desel_try && auto_sel)) begin
            sel_reg <= i_wdata[1:0];
          end
          if (wr_cmd && i_wdata[`HFAC_CMD_RCEN_BIT]) begin
            rc_sw_reg <= 1'b1;
          end else if (wr_cmd && i_wdata[`HFAC_CMD_RCDIS_BIT]) begin
            rc_sw_reg <= 1'b0;
          end
        end
      end
    end
  end

  // read data in the cycle after the strobe
  always @* begin
    rdata_next = 32'h0000_0000;
    case (i_addr)
      `HFAC_OFS_CTRL: rdata_next = ctrl_reg;
      `HFAC_OFS_XCTRL: rdata_next = {30'h0, auto_reg};
      `HFAC_OFS_STATUS: rdata_next = {25'h0, i_crystal_request, rc_ready, xtal_ready,
        o_fast_rc_osc_en, o_fast_crystal_osc_en, sel_reg};
      `HFAC_OFS_FLAGS: rdata_next = {28'h0, flags_reg};
      `HFAC_OFS_FLAGEN: rdata_next = {28'h0, flagen_reg};
      `HFAC_OFS_ROUTE: rdata_next = {30'h0, pen_reg};
      `HFAC_OFS_EXPDIV: rdata_next = {{(32-DIVW){1'b0}}, expdiv_reg};
      `HFAC_OFS_RETAIN: rdata_next = {25'h0, retain_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // decoded from the strobe cycle's own address, so the word stands for
  // exactly the one cycle after the strobe and the master never waits
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= 32'h0000_0000;
      if (i_rd) begin
        o_rdata <= rdata_next;
      end
    end
  end

  // energy mode gating of oscillators and clocks
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_fast_crystal_osc_en <= 1'b0;
      o_fast_rc_osc_en <= 1'b1;
      o_aux_fast_rc_osc_en <= 1'b0;
      o_slow_rc_osc_en <= 1'b0;
      o_slow_crystal_osc_en <= 1'b0;
      o_ultra_slow_rc_osc_en <= 1'b1;
      o_source_clock_sel <= `HFAC_SRC_RC;
      o_main_clock_en <= 1'b0;
      o_aux_clock_en <= 1'b0;
      o_low_freq_a_clock_en <= 1'b0;
      o_low_freq_b_clock_en <= 1'b0;
      o_low_freq_e_clock_en <= 1'b0;
      o_watchdog_clock_en <= 1'b0;
      o_cryo_timer_clock_en <= 1'b0;
      o_rf_sense_clock_en <= 1'b0;
      o_low_power_bus_wait <= 1'b0;
      o_clk_out0 <= 1'b0;
      o_clk_out1 <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_fast_crystal_osc_en <= hf_mode && (auto_en || xtal_sw_reg);
      o_fast_rc_osc_en <= hf_mode && rc_sw_reg;
      o_aux_fast_rc_osc_en <= hf_mode || ((i_energy_mode == `HFAC_EM_DEEP || em_stop) &&
        (i_adc_uses_aux || retain_reg[`HFAC_RET_ADC]));
      o_aux_clock_en <= hf_mode || ((i_energy_mode == `HFAC_EM_DEEP || em_stop) &&
        i_adc_uses_aux);
      o_slow_rc_osc_en <= !em_stop && (!(em_hib || em_shut) ||
        retain_reg[`HFAC_RET_SLOW]);
      o_slow_crystal_osc_en <= !em_stop && (!(em_hib || em_shut) ||
        retain_reg[`HFAC_RET_SLOW]);
      o_ultra_slow_rc_osc_en <= !em_shut || retain_reg[`HFAC_RET_ULTRA];
      o_source_clock_sel <= sel_reg;
      o_main_clock_en <= hf_mode;
      o_low_freq_a_clock_en <= !em_hib && !em_shut &&
        (!em_stop || retain_reg[`HFAC_RET_ULF_SRC]);
      o_low_freq_b_clock_en <= !em_hib && !em_shut &&
        (!em_stop || retain_reg[`HFAC_RET_ULF_SRC]);
      o_watchdog_clock_en <= !em_hib && !em_shut &&
        (!em_stop || retain_reg[`HFAC_RET_ULF_SRC]);
      o_low_freq_e_clock_en <= em_hib ? retain_reg[`HFAC_RET_LFE] :
        (!em_shut && (!em_stop || retain_reg[`HFAC_RET_ULF_SRC]));
      o_cryo_timer_clock_en <= (em_hib || em_shut) ? retain_reg[`HFAC_RET_CRYO] :
        (!em_stop || retain_reg[`HFAC_RET_ULF_SRC]);
      o_rf_sense_clock_en <= (em_hib || em_shut) ? retain_reg[`HFAC_RET_RFS] :
        (!em_stop || retain_reg[`HFAC_RET_ULF_SRC]);
      o_low_power_bus_wait <= ctrl_reg[`HFAC_CTRL_WAIT_BIT];
      o_clk_out0 <= pen_reg[0] &&
        hfac_pick(ctrl_reg[`HFAC_CTRL_SEL0_LSB +: 4], xtal_q, rc_q, exp_level);
      o_clk_out1 <= pen_reg[1] &&
        hfac_pick(ctrl_reg[`HFAC_CTRL_SEL1_LSB +: 4], xtal_q, rc_q, exp_level);
      o_irq <= |(flags_reg & flagen_reg);
    end
  end
endmodule

// [test/hfac_osc_model.sv]
/*
  oscillator stand-ins: raw clock levels and ready pins.
  assumes enables from the clock control block on one core clock.
*/
`timescale 1ns/1ps
module hfac_osc_model #(
  parameter READY_DLY = 12
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // enables: ultra, slow crystal, slow rc, aux, fast rc, fast crystal
  input wire [5:0] i_en,
  // clock levels and ready pins
  output reg [5:0] o_clk,
  output reg o_xtal_ready,
  output reg o_rc_ready
);
  integer xcnt;
  integer rcnt;
  // a stopped oscillator holds its output low and drops ready at once
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_clk <= 6'h00;
      xcnt <= 0;
      rcnt <= 0;
      o_xtal_ready <= 1'b0;
      o_rc_ready <= 1'b0;
    end else begin
      o_clk <= ~o_clk & i_en;
      xcnt <= i_en[0] ? xcnt + (xcnt < READY_DLY) : 0;
      rcnt <= i_en[1] ? rcnt + (rcnt < READY_DLY) : 0;
      o_xtal_ready <= i_en[0] && xcnt == READY_DLY;
      o_rc_ready <= i_en[1] && rcnt == READY_DLY;
    end
  end
endmodule

// [test/hfac_clock_ctrl_assertions.sv]
/*
  port checker for the fast crystal autostart clock control.
  assumes one core clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
`include "hfac_consts.vh"
module hfac_clock_ctrl_assertions (
  // clock, reset and register writes
  input wire i_core_clk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  // mode inputs
  input wire [2:0] i_energy_mode,
  input wire i_adc_uses_aux,
  // watched outputs
  input wire o_fast_crystal_osc_en,
  input wire o_fast_rc_osc_en,
  input wire o_aux_fast_rc_osc_en,
  input wire o_slow_rc_osc_en,
  input wire o_slow_crystal_osc_en,
  input wire o_ultra_slow_rc_osc_en,
  input wire [1:0] o_source_clock_sel,
  input wire o_main_clock_en,
  input wire o_aux_clock_en,
  input wire o_low_freq_a_clock_en,
  input wire o_low_freq_b_clock_en,
  input wire o_low_freq_e_clock_en,
  input wire o_watchdog_clock_en
);
  reg [1:0] auto_reg;
  wire act = i_energy_mode <= `HFAC_EM_SLEEP;
  wire low = i_energy_mode == `HFAC_EM_DEEP || i_energy_mode == `HFAC_EM_STOP;
  wire hib = i_energy_mode == `HFAC_EM_HIBER || i_energy_mode == `HFAC_EM_SHUT;
  wire sel_x = o_source_clock_sel == `HFAC_SRC_XTAL;
  wire lf_any = o_low_freq_a_clock_en || o_low_freq_b_clock_en || o_watchdog_clock_en;
  // shadow of the autostart bits, so no internal probes are needed
  always @(posedge i_core_clk) begin
    if (i_rst)
      auto_reg <= 2'h0;
    else if (i_wr && i_addr == `HFAC_OFS_XCTRL)
      auto_reg <= i_wdata[1:0];
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  auto_enable_a:
    assert property ((act && auto_reg != 2'h0) [*4] |-> o_fast_crystal_osc_en) else $error("no auto enable");
  auto_select_a:
    assert property ((act && auto_reg[1]) [*4] |-> sel_x) else $error("no auto select");
  select_at_once_a:
    assert property ($rose(auto_reg[1]) && act ##1 act [*2] |-> sel_x) else $error("select late");
  hf_off_low_a:
    assert property ((!act) [*4] |-> !(o_main_clock_en || o_fast_crystal_osc_en || o_fast_rc_osc_en))
      else $error("fast clock on in low mode");
  hf_on_active_a:
    assert property (act [*4] |-> o_main_clock_en) else $error("main clock off");
  aux_kept_a:
    assert property ((low && i_adc_uses_aux) [*4] |-> o_aux_fast_rc_osc_en && o_aux_clock_en)
      else $error("aux dropped");
  aux_off_a:
    assert property ((hib || (low && !i_adc_uses_aux)) [*4] |-> !(o_aux_fast_rc_osc_en || o_aux_clock_en))
      else $error("aux on");
  slow_stop_off_a:
    assert property ((i_energy_mode == `HFAC_EM_STOP) [*4] |-> !(o_slow_rc_osc_en || o_slow_crystal_osc_en))
      else $error("slow osc on in stop");
  ultra_on_a:
    assert property ((i_energy_mode != `HFAC_EM_SHUT) [*4] |-> o_ultra_slow_rc_osc_en) else $error("ultra off");
  hib_lf_off_a:
    assert property (hib [*4] |-> !lf_any && !(i_energy_mode == `HFAC_EM_SHUT && o_low_freq_e_clock_en))
      else $error("low freq clock on");
  cover property (sel_x && act && auto_reg[1]);
  cover property (low && i_adc_uses_aux && o_aux_clock_en);
  cover property (hib && o_low_freq_e_clock_en);
endmodule

bind hfac_clock_ctrl hfac_clock_ctrl_assertions chk_i (
  .i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_energy_mode, .i_adc_uses_aux,
  .o_fast_crystal_osc_en, .o_fast_rc_osc_en, .o_aux_fast_rc_osc_en, .o_slow_rc_osc_en,
  .o_slow_crystal_osc_en, .o_ultra_slow_rc_osc_en, .o_source_clock_sel, .o_main_clock_en,
  .o_aux_clock_en, .o_low_freq_a_clock_en, .o_low_freq_b_clock_en, .o_low_freq_e_clock_en,
  .o_watchdog_clock_en
);

// [test/tb_hfac_clock_ctrl.sv]
/*
  self-checking bench for the fast crystal autostart clock control.
  assumes the oscillator stand-in model and the bound port checker.
*/
`timescale 1ns/1ps
`include "hfac_consts.vh"
module tb_hfac_clock_ctrl;
  localparam [7:0] XC = `HFAC_OFS_XCTRL;
  localparam [7:0] OC = `HFAC_OFS_OSCCMD;
  localparam [7:0] SC = `HFAC_OFS_SELCMD;
  localparam [7:0] FL = `HFAC_OFS_FLAGS;
  localparam [31:0] DE = 32'h1 << `HFAC_FLG_DISERR;
  localparam [31:0] AS = 32'h1 << `HFAC_FLG_AUTOSW;
  localparam [31:0] XOFF = 32'h1 << `HFAC_CMD_XDIS_BIT;
  reg i_core_clk = 1'b0;
  reg i_rst = 1'b1;
  reg [7:0] i_addr = 8'h00;
  reg [31:0] i_wdata = 32'h0;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg [2:0] i_energy_mode = 3'h0;
  reg i_crystal_request = 1'b0;
  reg i_crystal_sync_busy = 1'b0;
  reg i_adc_uses_aux = 1'b0;
  reg [31:0] c;
  reg [6:0] ret;
  reg p0;
  wire [31:0] o_rdata;
  wire [1:0] o_source_clock_sel;
  wire [5:0] en;
  wire [5:0] oclk;
  wire xrdy, rrdy, mce, ace, lfa, lfb, lfe, wde, cre, rfe, lpw, co0, co1, irq;
  integer fails = 0;
  integer n_compared = 0;
  integer seed = 85058;
  integer expf = 0;
  integer k, m, n0, n1;

  hfac_clock_ctrl dut (
    .i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_energy_mode,
    .i_crystal_request, .i_crystal_sync_busy, .i_adc_uses_aux,
    .i_fast_crystal_osc_ready(xrdy), .i_fast_rc_osc_ready(rrdy),
    .i_fast_crystal_osc_clk(oclk[0]), .i_fast_rc_osc_clk(oclk[1]),
    .i_aux_fast_rc_osc_clk(oclk[2]), .i_slow_rc_osc_clk(oclk[3]),
    .i_slow_crystal_osc_clk(oclk[4]), .i_ultra_slow_rc_osc_clk(oclk[5]),
    .o_fast_crystal_osc_en(en[0]), .o_fast_rc_osc_en(en[1]), .o_aux_fast_rc_osc_en(en[2]),
    .o_slow_rc_osc_en(en[3]), .o_slow_crystal_osc_en(en[4]), .o_ultra_slow_rc_osc_en(en[5]),
    .o_source_clock_sel, .o_main_clock_en(mce), .o_aux_clock_en(ace),
    .o_low_freq_a_clock_en(lfa), .o_low_freq_b_clock_en(lfb), .o_low_freq_e_clock_en(lfe),
    .o_watchdog_clock_en(wde), .o_cryo_timer_clock_en(cre), .o_rf_sense_clock_en(rfe),
    .o_low_power_bus_wait(lpw), .o_clk_out0(co0), .o_clk_out1(co1), .o_irq(irq)
  );
  hfac_osc_model osc (
    .i_core_clk, .i_rst, .i_en(en), .o_clk(oclk), .o_xtal_ready(xrdy), .o_rc_ready(rrdy)
  );

  initial begin
    forever #20 i_core_clk = ~i_core_clk;
  end
  always @(posedge co0) n0 = n0 + 1;
  always @(posedge co1) n1 = n1 + 1;

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge i_core_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
    end
  endtask
  // read data stands only in the cycle after the strobe
  task rdchk(input [7:0] a, input [31:0] e);
    begin
      @(posedge i_core_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, e);
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge i_core_clk);
      #1;
    end
  endtask
  task clr;
    begin
      wr(`HFAC_OFS_FLAGCLR, 32'hF);
      expf = 0;
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  initial begin
    repeat (20000) @(posedge i_core_clk);
    fails = fails + 1;
    tally_and_finish;
  end

  initial begin
    repeat (6) @(posedge i_core_clk);
    i_rst <= 1'b0;
    tick(2);
    chk({en[1:0], en[5], o_source_clock_sel}, 5'b10100);
    rdchk(FL, 0);
    rdchk(`HFAC_OFS_CTRL, 0);
    wr(8'h40, $random(seed));
    rdchk(8'h40, 0);
    $display("test reset done");
    // no autostart: deselect and disable honoured although requested
    i_crystal_request <= 1'b1;
    wr(OC, 32'h1 << `HFAC_CMD_XEN_BIT);
    wr(SC, `HFAC_SRC_XTAL);
    tick(20);
    chk(o_source_clock_sel, `HFAC_SRC_XTAL);
    rdchk(`HFAC_OFS_STATUS, 32'h7D);
    wr(SC, `HFAC_SRC_RC);
    wr(OC, XOFF);
    tick(4);
    chk({en[0], o_source_clock_sel}, 3'b000);
    rdchk(FL, 0);
    $display("test manual done");
    // bench clock is 25 MHz, so flash and divider settings may stay as they are
    wr(`HFAC_OFS_CTRL, 32'h1 << `HFAC_CTRL_WAIT_BIT);
    wr(XC, 32'h1);
    tick(4);
    chk(en[0], 1'b1);
    wr(`HFAC_OFS_FLAGEN, DE);
    wr(OC, XOFF);
    tick(4);
    chk({en[0], irq}, 2'b11);
    expf = DE;
    rdchk(FL, expf);
    rdchk(FL, expf);
    clr;
    tick(3);
    chk(irq, 1'b0);
    $display("test disable done");
    // crystal starts cold, so the switch must not wait for ready
    wr(XC, 32'h0);
    wr(OC, XOFF);
    tick(4);
    wr(XC, 32'h3);
    tick(3);
    chk({xrdy, en[1:0], o_source_clock_sel}, 5'b00101);
    expf = AS | (32'h1 << `HFAC_FLG_RCOFF);
    rdchk(FL, expf);
    wr(SC, `HFAC_SRC_SLOWRC);
    tick(3);
    chk(o_source_clock_sel, `HFAC_SRC_XTAL);
    expf = expf | DE;
    rdchk(FL, expf);
    clr;
    wr(XC, 32'h0);
    wr(SC, `HFAC_SRC_SLOWX);
    tick(3);
    chk(o_source_clock_sel, `HFAC_SRC_SLOWX);
    p0 = en[4];
    wr(XC, 32'h2);
    tick(3);
    chk({en[4], en[1], o_source_clock_sel}, {p0, 1'b0, `HFAC_SRC_XTAL});
    rdchk(FL, AS);
    wr(XC, 32'h0);
    clr;
    $display("test autoswitch done");
    for (k = 0; k < 2; k = k + 1) begin
      i_crystal_sync_busy <= k[0];
      clr;
      wr(`HFAC_OFS_XCFG, $random(seed));
      rdchk(FL, k << `HFAC_FLG_CFGERR);
    end
    i_crystal_sync_busy <= 1'b0;
    wr(`HFAC_OFS_CTRL, 32'h1 << `HFAC_CTRL_WAIT_BIT);
    tick(3);
    chk(lpw, 1'b1);
    c = 32'h0;
    c[8:5] = `HFAC_OUT_EXP;
    c[3:0] = `HFAC_OUT_ULF;
    wr(`HFAC_OFS_CTRL, c);
    wr(`HFAC_OFS_EXPDIV, 32'h3);
    tick(1);
    chk(lpw, 1'b0);
    for (k = 0; k < 2; k = k + 1) begin
      wr(`HFAC_OFS_ROUTE, k * 3);
      tick(3);
      n0 = 0;
      n1 = 0;
      tick(32);
      if (k == 0)
        chk(n0 + n1, 0);
      else
        chk({n0 >= 15 && n0 <= 17, n1 >= 7 && n1 <= 9}, 2'b11);
    end
    $display("test pins done");
    wr(XC, 32'h1);
    for (k = 0; k < 24; k = k + 1) begin
      m = {$random(seed)} % 6;
      ret = $random(seed);
      ret[5] = 1'b0;
      wr(`HFAC_OFS_RETAIN, {25'h0, ret});
      @(posedge i_core_clk);
      i_energy_mode <= m[2:0];
      i_adc_uses_aux <= $random(seed);
      tick(5);
      chk({mce, en[0]}, {2{m < 2}});
      chk(en[5], m != 5 || ret[1]);
      if (m > 1)
        chk({en[2], ace}, {2{m < 4 && i_adc_uses_aux}});
      if (m > 2)
        chk({en[3], en[4]}, {2{m > 3 && ret[0]}});
      if (m == 3)
        chk({lfa, lfb, wde, lfe, cre, rfe}, {6{ret[6]}});
      if (m > 3)
        chk({lfa, lfb, wde, lfe, cre, rfe}, {3'b000, m == 4 && ret[2], ret[3], ret[4]});
    end
    $display("test modes done");
    tally_and_finish;
  end
endmodule
